// ---- design/analog_input_diag_record.sv ----
`timescale 1ns/100ps
// Function
// - record set 01h serves full record, 00h serves only first four bytes.
// - CANopen index 2F01h serves full record, 2F00h first four bytes.
// - EtherCAT index 5005h, one field per subindex, 02h summary to 13h timestamp.
// - summary byte flags module, internal, external, channel, aux supply, param.
// - module info byte is 15h: class 0101b, channel info present.
// - internal byte flags buffer overflow, communication error, lost interrupt.
// - channel type byte reads 71h, analog input.
// - diagnostic bits per channel reads 08h.
// - channel count reads 02h.
// - group error byte bit 0 for group 0, bit 1 for group 1.
// - channel byte flags param, wire break, lost interrupt, underflow, overflow.
// - final four bytes hold ticker value captured at the diagnostic event.
// - 32-bit microsecond ticker, zero at power-up, wraps after maximum.
// - incoming event on fault, going event on clear, changes between ignored.
module analog_input_diag_record
  import diag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = US_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         module_fail,
  input  wire logic         aux_supply_missing,
  input  wire logic         param_error,
  input  wire logic         diag_buffer_overflow,
  input  wire logic         comm_error,
  input  wire logic         irq_lost,
  input  wire logic [1:0]   ch_param_error,
  input  wire logic [1:0]   ch_wire_break,
  input  wire logic [1:0]   ch_irq_lost,
  input  wire logic [1:0]   ch_underflow,
  input  wire logic [1:0]   ch_overflow,
  input  wire logic         rd_req,
  input  wire logic [1:0]   rd_path,
  input  wire logic [15:0]  rd_select,
  input  wire logic [7:0]   rd_offset,
  output logic              rd_valid,
  output logic              rd_err,
  output logic [31:0]       rd_data,
  output logic              diag_incoming,
  output logic              diag_going,
  output logic              diag_active,
  output logic [31:0]       us_ticker
);

  // ==========================================================
  // input synchronisers
  localparam int unsigned NRAW = 16;

  logic [NRAW-1:0] raw;
  logic [NRAW-1:0] s1_q;
  logic [NRAW-1:0] s2_q;
  logic [NRAW-1:0] s3_q;
  logic [NRAW-1:0] flt_q;

  assign raw = {ch_overflow, ch_underflow, ch_irq_lost, ch_wire_break,
                ch_param_error, irq_lost, comm_error, diag_buffer_overflow,
                param_error, aux_supply_missing, module_fail};

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts only once two stages agree, filtering one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < NRAW; g++) begin : gen_filt
      always_ff @(posedge clk) begin
        if (rst) begin
          flt_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          flt_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  logic       f_mod_fail;
  logic       f_aux;
  logic       f_param;
  logic       f_buf_ovf;
  logic       f_comm;
  logic       f_irq_lost;
  logic [1:0] f_ch_param;
  logic [1:0] f_ch_wire;
  logic [1:0] f_ch_irq;
  logic [1:0] f_ch_under;
  logic [1:0] f_ch_over;

  assign {f_ch_over, f_ch_under, f_ch_irq, f_ch_wire, f_ch_param,
          f_irq_lost, f_comm, f_buf_ovf, f_param, f_aux, f_mod_fail} = flt_q;

  // ==========================================================
  // microsecond ticker
  logic [7:0]  div_q;
  logic        us_tick;
  logic [31:0] ticker_q;

  assign us_tick = (div_q == 8'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 8'h00;
    end else if (us_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // wraps to zero after all ones by plain overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      ticker_q <= 32'h0000_0000;
    end else if (us_tick) begin
      ticker_q <= ticker_q + 32'h0000_0001;
    end
  end

  assign us_ticker = ticker_q;

  // ==========================================================
  // live fault bytes
  logic [7:0] live_internal;
  logic [7:0] live_ch [NUM_CH];
  logic [2:0] live_mod;

  always_comb begin
    live_internal = 8'h00;
    live_internal[INT_BUF_OVF] = f_buf_ovf;
    live_internal[INT_COMM]    = f_comm;
    live_internal[INT_PI_LOST] = f_irq_lost;
  end

  assign live_mod = {f_param, f_aux, f_mod_fail};

  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_live
      always_comb begin
        live_ch[g] = 8'h00;
        live_ch[g][CH_PARAM]      = f_ch_param[g];
        live_ch[g][CH_WIRE_BREAK] = f_ch_wire[g];
        live_ch[g][CH_PI_LOST]    = f_ch_irq[g];
        live_ch[g][CH_UNDERFLOW]  = f_ch_under[g];
        live_ch[g][CH_OVERFLOW]   = f_ch_over[g];
      end
    end
  endgenerate

  // ==========================================================
  // incoming and going events
  // unit 0 is the module itself, units 1.. are the channels
  localparam int unsigned NUNIT = NUM_CH + 1;

  logic [NUNIT-1:0] cause;
  logic [NUNIT-1:0] active_q;
  logic [NUNIT-1:0] inc;
  logic [NUNIT-1:0] gone;

  always_comb begin
    cause[0] = (|live_mod) | (|live_internal);
    for (int u = 1; u < NUNIT; u++) begin
      cause[u] = |live_ch[u-1];
    end
  end

  assign inc  = cause & ~active_q;
  assign gone = ~cause & active_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= '0;
    end else begin
      active_q <= cause;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      diag_incoming <= 1'b0;
      diag_going    <= 1'b0;
    end else begin
      diag_incoming <= |inc;
      diag_going    <= |gone;
    end
  end

  assign diag_active = |active_q;

  // ==========================================================
  // recorded diagnostic fields
  // a unit's bytes move only on its own edge, so changes while it stays
  // faulty are dropped until the going event
  logic [2:0]  rec_mod_q;
  logic [7:0]  rec_internal_q;
  logic [7:0]  rec_ch_q [NUM_CH];
  logic [31:0] rec_ts_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_mod_q      <= 3'h0;
      rec_internal_q <= ZERO_BYTE_RST;
    end else if (inc[0] || gone[0]) begin
      rec_mod_q      <= live_mod;
      rec_internal_q <= live_internal;
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_rec
      always_ff @(posedge clk) begin
        if (rst) begin
          rec_ch_q[g] <= ZERO_BYTE_RST;
        end else if (inc[g+1] || gone[g+1]) begin
          rec_ch_q[g] <= live_ch[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_ts_q <= 32'h0000_0000;
    end else if ((|inc) || (|gone)) begin
      rec_ts_q <= ticker_q;
    end
  end

  // ==========================================================
  // record assembly
  logic [7:0]             summary;
  logic [7:0]             group_err;
  logic [8*REC_BYTES-1:0] rec_vec;

  always_comb begin
    group_err = 8'h00;
    for (int c = 0; c < NUM_CH; c++) begin
      group_err[c] = |rec_ch_q[c];
    end
  end

  always_comb begin
    summary = 8'h00;
    summary[SUM_MOD_FAIL] = rec_mod_q[0];
    summary[SUM_INTERNAL] = |rec_internal_q;
    summary[SUM_EXTERNAL] = rec_ch_q[0][CH_WIRE_BREAK] | rec_ch_q[1][CH_WIRE_BREAK];
    summary[SUM_CHANNEL]  = |group_err;
    summary[SUM_AUX_MISS] = rec_mod_q[1];
    summary[SUM_PARAM]    = rec_mod_q[2] | rec_ch_q[0][CH_PARAM] | rec_ch_q[1][CH_PARAM];
  end

  always_comb begin
    rec_vec = '0;
    rec_vec[8*OFF_SUMMARY  +: 8]  = summary;
    rec_vec[8*OFF_MODINFO  +: 8]  = MODINFO_RST;
    rec_vec[8*OFF_RESERVED +: 8]  = ZERO_BYTE_RST;
    rec_vec[8*OFF_INTERNAL +: 8]  = rec_internal_q;
    rec_vec[8*OFF_CHTYPE   +: 8]  = CHTYPE_RST;
    rec_vec[8*OFF_DIAG_BITS_PER_CHANNEL   +: 8]  = DIAG_BITS_PER_CHANNEL_RST;
    rec_vec[8*OFF_CHANNEL_COUNT    +: 8]  = CHANNEL_COUNT_RST;
    rec_vec[8*OFF_GROUPERR +: 8]  = group_err;
    for (int c = 0; c < NUM_CH; c++) begin
      rec_vec[8*(OFF_CHANNEL0_ERROR+c) +: 8] = rec_ch_q[c];
    end
    rec_vec[8*OFF_TIMESTAMP +: 32] = rec_ts_q;
  end

  // ==========================================================
  // access decode
  // returns {error, snapshot, wide, byte address}
  function automatic logic [7:0] decode(input logic [1:0]  path,
                                        input logic [15:0] sel,
                                        input logic [7:0]  off);
    logic       err;
    logic       snap;
    logic       wide;
    logic [4:0] addr;
    err  = 1'b0;
    snap = (off == 8'h00);
    wide = 1'b0;
    addr = off[4:0];
    case (path)
      PATH_RECORD_SET, PATH_CANOPEN: begin
        if (sel == ((path == PATH_CANOPEN) ? CO_FULL : RS_FULL)) begin
          err = (32'(off) >= REC_BYTES);
        end else if (sel == ((path == PATH_CANOPEN) ? CO_SHORT : RS_SHORT)) begin
          err = (32'(off) >= SHORT_BYTES);
        end else begin
          err = 1'b1;
        end
      end
      PATH_ETHERCAT: begin
        snap = 1'b1;
        if (sel != ECAT_INDEX) begin
          err = 1'b1;
        end else if (off >= ECAT_SUB_FIRST && off <= ECAT_SUB_LAST) begin
          addr = 5'(off - ECAT_SUB_FIRST);
        end else if (off == ECAT_SUB_TS) begin
          addr = 5'(OFF_TIMESTAMP);
          wide = 1'b1;
        end else begin
          err = 1'b1;
        end
      end
      default: begin
        err = 1'b1;
      end
    endcase
    return {err, snap & ~err, wide, addr};
  endfunction

  // ==========================================================
  // read pipeline and snapshot store
  snap_if sp ();

  logic [7:0] dec;
  logic       p1_valid_q;
  logic       p1_err_q;
  logic       p1_wide_q;
  logic [4:0] p1_addr_q;
  logic       p2_valid_q;
  logic       p2_err_q;
  logic       p2_wide_q;
  logic       rd_valid_q;
  logic       rd_err_q;
  logic [31:0] rd_data_q;

  assign dec = decode(rd_path, rd_select, rd_offset);

  // the first byte of a record set or CANopen read refreshes the snapshot, and so does
  // every EtherCAT subindex read; later bytes of a record set or CANopen read come
  // from it even if a new event lands meanwhile
  assign sp.we    = rd_req & dec[6];
  assign sp.wdata = rec_vec;
  assign sp.raddr = p1_addr_q;

  snap_store u_store (
    .clk (clk),
    .sp  (sp.store)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      p1_valid_q <= 1'b0;
      p1_err_q   <= 1'b0;
      p1_wide_q  <= 1'b0;
      p1_addr_q  <= 5'h00;
    end else begin
      p1_valid_q <= rd_req;
      p1_err_q   <= dec[7];
      p1_wide_q  <= dec[5];
      p1_addr_q  <= dec[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      p2_valid_q <= 1'b0;
      p2_err_q   <= 1'b0;
      p2_wide_q  <= 1'b0;
    end else begin
      p2_valid_q <= p1_valid_q;
      p2_err_q   <= p1_err_q;
      p2_wide_q  <= p1_wide_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_err_q   <= 1'b0;
      rd_data_q  <= 32'h0000_0000;
    end else begin
      rd_valid_q <= p2_valid_q;
      rd_err_q   <= p2_valid_q & p2_err_q;
      if (!p2_valid_q || p2_err_q) begin
        rd_data_q <= 32'h0000_0000;
      end else if (p2_wide_q) begin
        rd_data_q <= sp.rdata;
      end else begin
        rd_data_q <= {24'h000000, sp.rdata[7:0]};
      end
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_err   = rd_err_q;
  assign rd_data  = rd_data_q;

endmodule // analog_input_diag_record

// ---- design/diag_pkg.sv ----
package diag_pkg;

  // ==========================================================
  // record layout (byte offsets)
  localparam int unsigned REC_BYTES     = 20;
  localparam int unsigned SHORT_BYTES   = 4;
  localparam int unsigned OFF_SUMMARY   = 0;
  localparam int unsigned OFF_MODINFO   = 1;
  localparam int unsigned OFF_RESERVED  = 2;
  localparam int unsigned OFF_INTERNAL  = 3;
  localparam int unsigned OFF_CHTYPE    = 4;
  localparam int unsigned OFF_DIAG_BITS_PER_CHANNEL    = 5;
  localparam int unsigned OFF_CHANNEL_COUNT     = 6;
  localparam int unsigned OFF_GROUPERR  = 7;
  localparam int unsigned OFF_CHANNEL0_ERROR    = 8;
  localparam int unsigned OFF_TIMESTAMP = 16;

  // ==========================================================
  // constant bytes and reset values
  localparam logic [7:0] MODINFO_RST   = 8'h15;
  localparam logic [7:0] CHTYPE_RST    = 8'h71;
  localparam logic [7:0] DIAG_BITS_PER_CHANNEL_RST    = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_RST     = 8'h02;
  localparam logic [7:0] ZERO_BYTE_RST = 8'h00;
  localparam int unsigned NUM_CH       = 2;

  // ==========================================================
  // field bit positions
  localparam int unsigned SUM_MOD_FAIL  = 0;
  localparam int unsigned SUM_INTERNAL  = 1;
  localparam int unsigned SUM_EXTERNAL  = 2;
  localparam int unsigned SUM_CHANNEL   = 3;
  localparam int unsigned SUM_AUX_MISS  = 4;
  localparam int unsigned SUM_PARAM     = 7;
  localparam int unsigned INT_BUF_OVF   = 3;
  localparam int unsigned INT_COMM      = 4;
  localparam int unsigned INT_PI_LOST   = 6;
  localparam int unsigned CH_PARAM      = 0;
  localparam int unsigned CH_WIRE_BREAK = 4;
  localparam int unsigned CH_PI_LOST    = 5;
  localparam int unsigned CH_UNDERFLOW  = 6;
  localparam int unsigned CH_OVERFLOW   = 7;

  // ==========================================================
  // access paths and selectors
  localparam logic [1:0]  PATH_RECORD_SET = 2'h0;
  localparam logic [1:0]  PATH_CANOPEN    = 2'h1;
  localparam logic [1:0]  PATH_ETHERCAT   = 2'h2;
  localparam logic [15:0] RS_FULL         = 16'h0001;
  localparam logic [15:0] RS_SHORT        = 16'h0000;
  localparam logic [15:0] CO_FULL         = 16'h2f01;
  localparam logic [15:0] CO_SHORT        = 16'h2f00;
  localparam logic [15:0] ECAT_INDEX      = 16'h5005;
  localparam logic [7:0]  ECAT_SUB_FIRST  = 8'h02;
  localparam logic [7:0]  ECAT_SUB_LAST   = 8'h11;
  localparam logic [7:0]  ECAT_SUB_TS     = 8'h13;

  // ==========================================================
  // timing
  localparam int unsigned CLK_NS    = 4;
  localparam int unsigned TICK_NS   = 1000;
  localparam int unsigned US_CYCLES = TICK_NS / CLK_NS;

endpackage

// ---- design/snap_if.sv ----
`timescale 1ns/100ps
interface snap_if;
  import diag_pkg::*;
  logic                   we;
  logic [8*REC_BYTES-1:0] wdata;
  logic [4:0]             raddr;
  logic [31:0]            rdata;

  modport writer (output we, output wdata, output raddr, input rdata);
  modport store  (input we, input wdata, input raddr, output rdata);
endinterface

// ---- design/snap_store.sv ----
`timescale 1ns/100ps
module snap_store
  import diag_pkg::*;
(
  input wire logic clk,
  snap_if.store    sp
);

  logic [7:0] mem_q [REC_BYTES];
  logic [31:0] rdata_q;

  // whole record written in one edge, so a read never sees a mix of two events
  always_ff @(posedge clk) begin
    if (sp.we) begin
      for (int i = 0; i < REC_BYTES; i++) begin
        mem_q[i] <= sp.wdata[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int k = 0; k < 4; k++) begin
      if (32'(sp.raddr) + 32'(k) < REC_BYTES) begin
        rdata_q[8*k +: 8] <= mem_q[32'(sp.raddr) + 32'(k)];
      end else begin
        rdata_q[8*k +: 8] <= 8'h00;
      end
    end
  end

  assign sp.rdata = rdata_q;

endmodule // snap_store

// ---- testbench/analog_input_diag_record_test.sv ----
`timescale 1ns/100ps
module analog_input_diag_record_test;
  import diag_pkg::*;
  localparam int unsigned TICK = 4;
  localparam logic [15:0] EC = 16'h5005;
  localparam logic [159:0] RST_REC = 160'h0002_0871_0000_1500;
  logic        clk, rst, rd_req, rd_valid, rd_err, diag_incoming, diag_going, diag_active;
  logic        module_fail, aux_supply_missing, param_error;
  logic        diag_buffer_overflow, comm_error, irq_lost;
  logic [1:0]  ch_param_error, ch_wire_break, ch_irq_lost, ch_underflow, ch_overflow, rd_path;
  logic [15:0] rd_select;
  logic [7:0]  rd_offset;
  logic [31:0] rd_data, us_ticker;
  int          failures, cmp_count;

  analog_input_diag_record #(.TICK_CYCLES(TICK)) uut (
    .clk, .rst, .module_fail, .aux_supply_missing, .param_error, .diag_buffer_overflow,
    .comm_error, .irq_lost, .ch_param_error, .ch_wire_break, .ch_irq_lost, .ch_underflow,
    .ch_overflow, .rd_req, .rd_path, .rd_select, .rd_offset, .rd_valid, .rd_err, .rd_data,
    .diag_incoming, .diag_going, .diag_active, .us_ticker);
  record_reader rdr (.clk, .rd_req, .rd_path, .rd_select, .rd_offset, .rd_valid, .rd_err,
    .rd_data);

  always #2 clk = ~clk;

  // ==========================================================
  // shared checks
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [1:0] p, input logic [15:0] s,
                       input logic [7:0] o, input logic e, input logic [31:0] x);
    logic [31:0] d;
    logic        er, ok;
    rdr.read(p, s, o, d, er, ok);
    chk({what, " answer"}, 32'h1, {31'h0, ok});
    chk({what, " refused"}, {31'h0, e}, {31'h0, er});
    chk(what, x, d);
  endtask

  task automatic wait_ev(input logic going);
    int n;
    n = 0;
    while (n < 40 && (going ? diag_going : diag_incoming) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk("event pulse", 32'h1, {31'h0, n < 40});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_record;
    for (int i = 0; i < 20; i++) begin
      rdchk("byte", 2'h0, 16'h0001, 8'(i), 1'b0, {24'h0, RST_REC[8*i+:8]});
    end
    for (int i = 0; i < 16; i++) begin
      rdchk("sub", 2'h2, EC, 8'(i + 2), 1'b0, {24'h0, RST_REC[8*i+:8]});
    end
  endtask

  task automatic t_refuse;
    rdchk("short set", 2'h0, 16'h0000, 8'h03, 1'b0, 32'h0);
    rdchk("short set", 2'h0, 16'h0000, 8'h04, 1'b1, 32'h0);
    rdchk("short idx", 2'h1, 16'h2f00, 8'h03, 1'b0, 32'h0);
    rdchk("short idx", 2'h1, 16'h2f00, 8'h04, 1'b1, 32'h0);
    rdchk("full idx", 2'h1, 16'h2f01, 8'h04, 1'b0, 32'h71);
    rdchk("full idx", 2'h1, 16'h2f01, 8'h14, 1'b1, 32'h0);
    rdchk("bad set", 2'h0, 16'h0002, 8'h00, 1'b1, 32'h0);
    rdchk("sub 01", 2'h2, EC, 8'h01, 1'b1, 32'h0);
    rdchk("sub 12", 2'h2, EC, 8'h12, 1'b1, 32'h0);
    rdchk("sub 14", 2'h2, EC, 8'h14, 1'b1, 32'h0);
    rdchk("bad idx", 2'h2, 16'h5004, 8'h02, 1'b1, 32'h0);
    rdchk("path 3", 2'h3, 16'h0001, 8'h00, 1'b1, 32'h0);
  endtask

  task automatic t_channel;
    logic [31:0] t, d;
    logic        er, ok;
    ch_wire_break[1] = 1'b1;
    ch_overflow[1] = 1'b1;
    wait_ev(1'b0);
    chk("active", 32'h1, {31'h0, diag_active});
    t = us_ticker;
    rdchk("summary", 2'h2, EC, 8'h02, 1'b0, 32'h0c);
    rdchk("group", 2'h2, EC, 8'h09, 1'b0, 32'h02);
    rdchk("ch0", 2'h2, EC, 8'h0a, 1'b0, 32'h00);
    rdchk("ch1", 2'h2, EC, 8'h0b, 1'b0, 32'h90);
    rdr.read(2'h2, EC, 8'h13, d, er, ok);
    cmp_count++;
    if (d !== t && d !== t - 32'h1) begin
      failures++;
      $display("BAD timestamp expected %h seen %h", t, d);
    end
    ch_underflow[1] = 1'b1;
    repeat (10) @(negedge clk);
    rdchk("ch1 held", 2'h2, EC, 8'h0b, 1'b0, 32'h90);
    {ch_wire_break, ch_overflow, ch_underflow} = 6'h00;
    wait_ev(1'b1);
    chk("active clear", 32'h0, {31'h0, diag_active});
    rdchk("ch1 clear", 2'h2, EC, 8'h0b, 1'b0, 32'h00);
    rdchk("summary clear", 2'h2, EC, 8'h02, 1'b0, 32'h00);
  endtask

  task automatic t_snapshot;
    rdchk("snap base", 2'h0, 16'h0001, 8'h00, 1'b0, 32'h00);
    ch_wire_break[0] = 1'b1;
    wait_ev(1'b0);
    rdchk("snap held", 2'h0, 16'h0001, 8'h08, 1'b0, 32'h00);
    rdchk("snap new", 2'h0, 16'h0001, 8'h00, 1'b0, 32'h0c);
    rdchk("snap ch0", 2'h0, 16'h0001, 8'h08, 1'b0, 32'h10);
    ch_wire_break[0] = 1'b0;
    wait_ev(1'b1);
  endtask

  task automatic t_module;
    {module_fail, aux_supply_missing, param_error} = 3'h7;
    {diag_buffer_overflow, comm_error, irq_lost} = 3'h7;
    ch_param_error[0] = 1'b1;
    ch_irq_lost[0] = 1'b1;
    ch_underflow[0] = 1'b1;
    wait_ev(1'b0);
    repeat (4) @(negedge clk);
    rdchk("summary", 2'h2, EC, 8'h02, 1'b0, 32'h9b);
    rdchk("internal", 2'h2, EC, 8'h05, 1'b0, 32'h58);
    rdchk("group", 2'h2, EC, 8'h09, 1'b0, 32'h01);
    rdchk("ch0", 2'h2, EC, 8'h0a, 1'b0, 32'h61);
    {module_fail, aux_supply_missing, param_error} = 3'h0;
    {diag_buffer_overflow, comm_error, irq_lost} = 3'h0;
    {ch_param_error, ch_irq_lost, ch_underflow} = 6'h00;
    wait_ev(1'b1);
    rdchk("summary clear", 2'h2, EC, 8'h02, 1'b0, 32'h00);
  endtask

  task automatic t_ticker;
    logic [31:0] t;
    t = us_ticker;
    for (int n = 0; n < 10 && us_ticker === t; n++) @(negedge clk);
    t = us_ticker;
    repeat (4 * TICK) @(negedge clk);
    chk("ticker", t + 32'h4, us_ticker);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    failures = 0;
    cmp_count = 0;
    {module_fail, aux_supply_missing, param_error} = 3'h0;
    {diag_buffer_overflow, comm_error, irq_lost} = 3'h0;
    {ch_param_error, ch_wire_break, ch_irq_lost, ch_underflow, ch_overflow} = 10'h000;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("ticker at start", 32'h0, us_ticker);
    t_reset_record();
    t_refuse();
    t_channel();
    t_snapshot();
    t_module();
    t_ticker();
    conclude();
  end

  // the whole run needs a few microseconds; this only cuts a hang
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule // analog_input_diag_record_test

// ---- testbench/diag_record_checker.sv ----
`timescale 1ns/100ps
module diag_record_chk
  import diag_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = US_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        rd_req,
  input wire logic [1:0]  rd_path,
  input wire logic [15:0] rd_select,
  input wire logic [7:0]  rd_offset,
  input wire logic        rd_valid,
  input wire logic        rd_err,
  input wire logic [31:0] rd_data,
  input wire logic [31:0] us_ticker
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // ticker watch
  logic [31:0] prev_q;
  int unsigned idle_q;
  always_ff @(posedge clk) begin
    prev_q <= us_ticker;
  end
  always_ff @(posedge clk) begin
    if (rst || us_ticker != prev_q) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end

  // ==========================================================
  // answer sequences
  sequence s_ok;
    ##3 (rd_valid && !rd_err);
  endsequence
  sequence s_bad;
    ##3 (rd_valid && rd_err);
  endsequence

  AST_LATENCY: assert property (rd_req |-> ##3 rd_valid)
    else $error("answer not three cycles after request");
  AST_NO_SPURIOUS: assert property (rd_valid |-> $past(rd_req, 3))
    else $error("answer without request");
  AST_DATA_ZERO: assert property ((!rd_valid || rd_err) |-> rd_data == 32'h0)
    else $error("data outside a good answer");
  AST_PATH_BAD: assert property (rd_req && rd_path == 2'h3 |-> s_bad)
    else $error("bad path not refused");
  AST_SHORT_SET: assert property (rd_req && rd_path == PATH_RECORD_SET
    && rd_select == RS_SHORT && rd_offset >= 8'h04 |-> s_bad)
    else $error("short set beyond four bytes not refused");
  AST_SHORT_IDX: assert property (rd_req && rd_path == PATH_CANOPEN
    && rd_select == CO_SHORT && rd_offset >= 8'h04 |-> s_bad)
    else $error("short index beyond four bytes not refused");
  AST_FULL_IDX: assert property (rd_req && rd_path == PATH_CANOPEN
    && rd_select == CO_FULL && rd_offset < 8'h14 |-> s_ok)
    else $error("full index byte refused");
  AST_TS_SUB: assert property (rd_req && rd_path == PATH_ETHERCAT
    && rd_select == ECAT_INDEX && rd_offset == 8'h13 |-> s_ok)
    else $error("timestamp subindex refused");
  AST_BYTE_WIDTH: assert property (rd_valid && $past(rd_path, 3) != PATH_ETHERCAT
    |-> rd_data[31:8] == 24'h0)
    else $error("byte answer has upper bits");
  AST_TICK_STEP: assert property (us_ticker != prev_q |-> us_ticker == prev_q + 32'h1)
    else $error("ticker did not step by one");
  AST_TICK_RATE: assert property (idle_q <= TICK_CYCLES)
    else $error("ticker stalled");
endmodule // diag_record_chk

bind analog_input_diag_record diag_record_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk(clk), .rst(rst), .rd_req(rd_req), .rd_path(rd_path), .rd_select(rd_select),
  .rd_offset(rd_offset), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
  .us_ticker(us_ticker));

// ---- testbench/record_reader.sv ----
`timescale 1ns/100ps
module record_reader (
  input  wire logic        clk,
  output logic             rd_req,
  output logic [1:0]       rd_path,
  output logic [15:0]      rd_select,
  output logic [7:0]       rd_offset,
  input  wire logic        rd_valid,
  input  wire logic        rd_err,
  input  wire logic [31:0] rd_data
);
  initial begin
    rd_req = 1'b0;
    rd_path = 2'h0;
    rd_select = 16'h0000;
    rd_offset = 8'h00;
  end

  // selectors are inverted once taken, so a design sampling them late reads garbage
  task automatic read(input logic [1:0] p, input logic [15:0] s, input logic [7:0] o,
                      output logic [31:0] d, output logic e, output logic ok);
    int n;
    @(negedge clk);
    rd_req = 1'b1;
    rd_path = p;
    rd_select = s;
    rd_offset = o;
    @(negedge clk);
    rd_req = 1'b0;
    rd_path = ~p;
    rd_select = ~s;
    rd_offset = ~o;
    n = 0;
    while (n < 6 && rd_valid !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    ok = (n == 2);
    d = rd_data;
    e = rd_err;
  endtask
endmodule // record_reader
